/* bench/htar_sram_model.sv */
`timescale 1ns/1ps

// external correction memory: no pull on the data lines
module htar_sram_model (
  // clock
  input wire logic core_clk_in,
  // memory pins
  input wire htar_pkg::htar_sram_type sram_in,
  output logic [7:0] dq_out
);
  logic [7:0] mem [0:65535]; // stored words
  logic [7:0] last_q = 8'h00; // last value put on the lines

  // store on a selected write, remember what was last driven
  always @(posedge core_clk_in) begin
    if (!sram_in.ce_b && !sram_in.we_b && sram_in.dq_oe) begin
      mem[sram_in.addr] <= sram_in.dout;
    end
    if (!sram_in.ce_b && !sram_in.oe_b) begin
      last_q <= mem[sram_in.addr];
    end
  end

  // undriven lines show the inverse so a stale value never passes
  assign dq_out = (!sram_in.ce_b && !sram_in.oe_b) ? mem[sram_in.addr] : ~last_q;
endmodule // htar_sram_model

/* bench/htar_top_chk.sv */
`timescale 1ns/1ps

// port-level watcher for host accesses, memory strobes and timing pulses
module htar_top_chk (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // register bus
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // memory and timing
  input wire htar_pkg::htar_sram_type sram_out,
  input wire logic internal_clk_en_out,
  input wire logic roller_step_timing_out,
  input wire logic line_abort_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  logic standby_q; // low_power_hold as last accepted from the host
  logic req; // any strobe raised
  assign req = avs_read_in || avs_write_in;

  // track the hold bit so the clock stop can be judged from the ports alone
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      standby_q <= 1'b0;
    end else if (avs_write_in && !avs_waitrequest_out && avs_address_in == htar_pkg::REG_MODE) begin
      standby_q <= avs_writedata_in[htar_pkg::MODE_HOLD_BIT];
    end
  end

  a_wait_release: assert property ($rose(rst_b_in) |-> avs_waitrequest_out && sram_out.ce_b)
    else $error("bus or memory active right after reset");
  a_ack_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("acknowledge longer than one cycle");
  a_ack_cause: assert property (!avs_waitrequest_out |-> $past(req))
    else $error("acknowledge without a request");
  a_fast_ack: assert property ($rose(req) && avs_address_in != htar_pkg::REG_SHADING |=> !avs_waitrequest_out)
    else $error("register access not answered in one cycle");
  a_shading_ack: assert property ($rose(req) && avs_address_in == htar_pkg::REG_SHADING
    |-> ##[1:8] !avs_waitrequest_out)
    else $error("correction port access not answered in time");
  a_sram_write: assert property (!sram_out.we_b |-> !sram_out.ce_b && sram_out.dq_oe && sram_out.oe_b)
    else $error("memory write strobe without select and drive");
  a_sram_scope: assert property (!sram_out.ce_b |-> req && avs_address_in == htar_pkg::REG_SHADING)
    else $error("memory selected outside a correction port access");
  a_abort_cause: assert property (line_abort_out
    |-> $past(avs_write_in && !avs_waitrequest_out && avs_address_in == htar_pkg::REG_CTRL
    && avs_writedata_in[htar_pkg::CTRL_RESET_BIT]))
    else $error("line abort without a reset write");
  a_clk_gap: assert property (internal_clk_en_out |=> !internal_clk_en_out [*8])
    else $error("internal clock enable too frequent");
  a_standby_clk: assert property (standby_q && $past(standby_q) |-> !internal_clk_en_out)
    else $error("internal clock runs in standby");
  a_roller_once: assert property (roller_step_timing_out |=> !roller_step_timing_out [*8])
    else $error("roller step pulse too long");

  c_shading_read: cover property (!avs_waitrequest_out && avs_read_in && avs_address_in == htar_pkg::REG_SHADING);
  c_abort: cover property (line_abort_out);
  c_roller: cover property (roller_step_timing_out);
  c_standby: cover property (standby_q ##16 standby_q);
endmodule // htar_top_chk

/* bench/htar_top_tb.sv */
`timescale 1ns/1ps

// host-side bench: register traffic, table transfers, standby and resets
module htar_top_tb;
  logic core_clk = 1'b0; // 10 MHz system clock
  logic rst_b = 1'b0; // hard reset, active low
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] be = 4'hF;
  logic [31:0] rdata;
  logic waitreq;
  htar_pkg::htar_sram_type sram;
  logic [7:0] dq;
  logic [6:0] pixel = 7'h00;
  logic bilevel;
  logic clk_en;
  logic roller;
  logic abort;
  logic ht_black; // dither decision
  logic kept; // line carries data under scale down
  logic [31:0] n; // kept lines counted by the bench
  logic [31:0] exp_q[$]; // expected read data, oldest first
  logic [6:0] tbl[64]; // host copy of table contents
  logic [7:0] v;
  integer seed = 32'hE797F299;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #50 core_clk = ~core_clk;

  htar_top #(.LINE_PIXELS(16)) i_htar_top (
    .core_clk_in(core_clk), .rst_b_in(rst_b),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .sram_out(sram), .sram_dq_in(dq), .pixel_in(pixel),
    .bilevel_black_out(bilevel), .halftone_black_out(ht_black),
    .internal_clk_en_out(clk_en), .roller_step_timing_out(roller),
    .line_kept_out(kept), .line_abort_out(abort)
  );

  htar_sram_model i_htar_sram_model (.core_clk_in(core_clk), .sram_in(sram), .dq_out(dq));

  // random pixels keep the decision logic busy
  always @(posedge core_clk) pixel <= 7'($random(seed));

  // hang guard, generous against the few thousand cycles expected
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      results();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  // one bus cycle: hold everything until waitrequest is sampled low
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= ~w;
    wr <= w;
    wdata <= {24'h000000, d};
    do @(posedge core_clk); while (waitreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  // the note goes in before the read so the watcher always finds it
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 8'h00);
  endtask

  // read watcher: data is sampled in the acknowledge cycle only
  always @(posedge core_clk) begin
    if (rd && waitreq === 1'b0) begin
      chk("readdata", exp_q.pop_front(), rdata);
    end
  end

  task automatic wait_px();
    repeat (40) @(posedge core_clk);
  endtask

  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    // halftone: one write past the end wraps onto entry 0
    wr_reg(htar_pkg::REG_MODE, 8'h00);
    wr_reg(htar_pkg::REG_CTRL, 8'h80);
    for (int i = 0; i < 65; i++) begin
      v = 8'($random(seed));
      tbl[i % 64] = {1'b0, v[5:0]};
      wr_reg(htar_pkg::REG_HALFTONE, v);
    end
    rd_reg(htar_pkg::REG_CTRL, 32'h00000001);
    be <= 4'h0;
    wr_reg(htar_pkg::REG_HALFTONE, 8'h3F); // lane off, must not store
    be <= 4'hF;
    wr_reg(htar_pkg::REG_CTRL, 8'h80);
    for (int i = 0; i < 64; i++) rd_reg(htar_pkg::REG_HALFTONE, {25'h0000000, tbl[i]});
    rd_reg(htar_pkg::REG_CTRL, 32'h00000000);
    // bus select set: table ports read zero and counters stay
    wr_reg(htar_pkg::REG_MODE, 8'h10);
    rd_reg(htar_pkg::REG_HALFTONE, 32'h00000000);
    rd_reg(htar_pkg::REG_SHADING, 32'h00000000);
    rd_reg(htar_pkg::REG_CTRL, 32'h00000000);
    wr_reg(htar_pkg::REG_MODE, 8'h00);
    $display("test halftone done");
    // correction memory through every memory clock setting
    for (int m = 0; m < 4; m++) begin
      wr_reg(htar_pkg::REG_MEMCFG, 8'(m * 8'h50));
      wr_reg(htar_pkg::REG_CTRL, 8'h80);
      for (int i = 0; i < 6; i++) begin
        v = 8'($random(seed));
        tbl[i] = v[6:0];
        wr_reg(htar_pkg::REG_SHADING, v);
      end
      wr_reg(htar_pkg::REG_CTRL, 8'h80);
      for (int i = 0; i < 6; i++) rd_reg(htar_pkg::REG_SHADING, {25'h0000000, tbl[i]});
    end
    $display("test shading done");
    // coefficient above every pixel gives black, zero gives white
    wr_reg(htar_pkg::REG_COEF, 8'h80);
    wait_px();
    chk("bilevel", 32'h00000001, {31'h00000000, bilevel});
    wr_reg(htar_pkg::REG_COEF, 8'h00);
    wait_px();
    chk("bilevel", 32'h00000000, {31'h00000000, bilevel});
    // standby clears the outputs but keeps the coefficient
    wr_reg(htar_pkg::REG_COEF, 8'h80);
    wr_reg(htar_pkg::REG_MODE, 8'h03);
    rd_reg(htar_pkg::REG_CTRL, 32'h00000080);
    wait_px();
    chk("bilevel", 32'h00000000, {31'h00000000, bilevel});
    chk("halftone", 32'h00000000, {31'h00000000, ht_black});
    wr_reg(htar_pkg::REG_MODE, 8'h00);
    wait_px();
    chk("bilevel", 32'h00000001, {31'h00000000, bilevel});
    $display("test standby done");
    // vertical scale down keeps nine lines out of every eleven
    wr_reg(htar_pkg::REG_SCALE, 8'h01);
    n = 32'h00000000;
    repeat (11) begin
      @(posedge roller);
      @(posedge core_clk);
      n = n + {31'h00000000, kept};
    end
    chk("kept lines", 32'h00000009, n);
    $display("test scale done");
    // hard reset in mid-run clears coefficient and table
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    wait_px();
    chk("bilevel", 32'h00000000, {31'h00000000, bilevel});
    chk("halftone", 32'h00000000, {31'h00000000, ht_black});
    rd_reg(htar_pkg::REG_HALFTONE, 32'h00000000);
    $display("test hard reset done");
    results();
  end
endmodule // htar_top_tb

bind htar_top htar_top_chk i_htar_top_chk (
  .core_clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_readdata_out, .avs_waitrequest_out, .sram_out, .internal_clk_en_out,
  .roller_step_timing_out, .line_abort_out
);

/* rtl/htar_halftone_mem.sv */
`timescale 1ns/1ps

// threshold storage: host port writes/reads, pixel port reads through a register
module htar_halftone_mem #(
  parameter int unsigned WORDS = htar_pkg::HALFTONE_WORDS,
  parameter int unsigned WIDTH = htar_pkg::HALFTONE_W
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // host port
  input wire logic host_we_in,
  input wire logic [$clog2(WORDS)-1:0] host_addr_in,
  input wire logic [WIDTH-1:0] host_wdata_in,
  output logic [WIDTH-1:0] host_rdata_out,
  // pixel port
  input wire logic standby_in,
  input wire logic [$clog2(WORDS)-1:0] pix_addr_in,
  output logic [WIDTH-1:0] pix_rdata_out
);

  logic [WIDTH-1:0] cell_q [WORDS];  // flip-flop storage, contents survive standby

  // host write at the accepting edge
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < WORDS; i++) begin
        cell_q[i] <= '0;
      end
    end else if (host_we_in) begin
      cell_q[host_addr_in] <= host_wdata_in;
    end
  end

  // host read is combinational so it can be captured in the same cycle
  assign host_rdata_out = cell_q[host_addr_in];

  // pixel read is frozen in standby so the array sees no toggling
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pix_rdata_out <= '0;
    end else if (!standby_in) begin
      pix_rdata_out <= cell_q[pix_addr_in];
    end
  end

endmodule // htar_halftone_mem

/* rtl/htar_pkg.sv */
package htar_pkg;

  // register indices (word addresses on the register bus)
  localparam logic [3:0] REG_CTRL = 4'h0;       // reset strobe, sensor setup
  localparam logic [3:0] REG_MEMCFG = 4'h1;     // memory clock and memory_config_field
  localparam logic [3:0] REG_MODE = 4'h2;       // bus_output_select, low_power_hold
  localparam logic [3:0] REG_COEF = 4'h6;       // threshold_coefficient
  localparam logic [3:0] REG_SCALE = 4'hC;      // vertical scale down enable
  localparam logic [3:0] REG_HALFTONE = 4'hE;   // halftone_table_port
  localparam logic [3:0] REG_SHADING = 4'hF;    // shading_table_port

  // field positions
  localparam int unsigned CTRL_RESET_BIT = 7;
  localparam int unsigned MEMCFG_CLK_LSB = 6;
  localparam int unsigned MEMCFG_CFG_LSB = 4;
  localparam int unsigned MODE_BUS_SEL_BIT = 4;
  localparam int unsigned MODE_HOLD_BIT = 0;
  localparam int unsigned MODE_MATRIX8_BIT = 1;
  localparam int unsigned SCALE_EN_BIT = 0;

  // reset values
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  localparam logic [7:0] SRAM_DATA_RESET = 8'h00;

  // table geometry
  localparam int unsigned HALFTONE_WORDS = 64;
  localparam int unsigned HALFTONE_W = 6;
  localparam int unsigned SHADING_W = 7;

  // timing: pixel period is sixteen system clocks
  localparam int unsigned PIXEL_DIV = 16;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [3:0] SCALE_NUM = 4'h9;      // lines kept ...
  localparam logic [3:0] SCALE_DEN = 4'hB;      // ... out of this many

  // host access sequencer, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ACK = 5'b00010,
    ST_MEM = 5'b00100,
    ST_SYNC = 5'b01000,
    ST_CAPT = 5'b10000
  } htar_state_type;

  // external correction memory pins, driven as one registered bundle
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] dout;
    logic dq_oe;
    logic ce_b;
    logic oe_b;
    logic we_b;
  } htar_sram_type;

  // one host request as seen by the sequencer
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] idx;
    logic [7:0] wdata;
  } htar_req_type;

endpackage

/* rtl/htar_top.sv */
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps

// Function
// - internal 64x6 threshold table, host read/write
// - reset bit returns halftone counter to zero
// - halftone port write stores, counter advances
// - halftone port read returns entry, advances
// - host reaches external correction memory
// - shading port write goes to memory
// - shading port read fetches memory entry
// - hard reset clears everything, stops clock
// - soft reset aborts line, clears counter
// - standby stops internal clock generator
// - standby keeps registers, clears pixel outputs, address counters
// - larger threshold coefficient gives darker output
// - roller step timing output drives feed
// - reset held while reset write pending
module htar_top #(
  parameter int unsigned LINE_PIXELS = 2048,   // pixels per line period
  parameter int unsigned SRAM_ADDR_W = 16      // correction memory address width
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // avalon-mm register slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // external correction memory
  output htar_pkg::htar_sram_type sram_out,
  input wire logic [7:0] sram_dq_in,
  // pixel path
  input wire logic [6:0] pixel_in,
  output logic bilevel_black_out,
  output logic halftone_black_out,
  // line timing
  output logic internal_clk_en_out,
  output logic roller_step_timing_out,
  output logic line_kept_out,
  output logic line_abort_out
);

  localparam int unsigned PIX_W = $clog2(LINE_PIXELS);
  localparam int unsigned HT_AW = $clog2(htar_pkg::HALFTONE_WORDS);

  // refuse sizes the counters cannot serve
  if (LINE_PIXELS < 16) begin : g_bad_line
    $error("LINE_PIXELS must be at least 16");
  end
  if (SRAM_ADDR_W < 16) begin : g_bad_addr
    $error("SRAM_ADDR_W must be at least 16");
  end

  // memory access length from the memory clock field
  function automatic logic [2:0] mem_cycles(input logic [1:0] mclk);
    mem_cycles = 3'(mclk) + 3'h1;
  endfunction

  // address wrap from memory_config_field: small, medium, full part
  function automatic logic [15:0] addr_wrap(input logic [15:0] a, input logic [1:0] cfg);
    case (cfg)
      2'h0: addr_wrap = a & 16'h1FFF;
      2'h1: addr_wrap = a & 16'h7FFF;
      default: addr_wrap = a;
    endcase
  endfunction

  // row-major cell index: four or eight cells per row
  function automatic logic [5:0] cell_index(input logic [2:0] row, input logic [2:0] col, input logic m8);
    cell_index = m8 ? {row, col} : {2'h0, row[1:0], col[1:0]};
  endfunction

  // register file, reset value everywhere
  logic [7:0] reg_q [16];
  logic [5:0] ht_addr_q;                  // halftone address counter
  logic [15:0] sh_addr_q;                 // correction memory address counter
  htar_pkg::htar_state_type state_q;
  htar_pkg::htar_req_type req;
  logic [2:0] mem_cnt_q;                  // wait cycles left on the memory
  logic [7:0] dq_meta_q;                  // first synchroniser stage
  logic [7:0] dq_sync_q;                  // second synchroniser stage
  logic [3:0] pix_div_q;                  // clock generator divider
  logic [PIX_W-1:0] pix_cnt_q;            // position inside the line
  logic [15:0] line_cnt_q;                // line period counter
  logic [3:0] scale_acc_q;                // fractional line keeper
  logic [4:0] scale_sum;
  logic [HT_AW-1:0] ht_pix_addr;
  logic [5:0] ht_host_rdata;
  logic [5:0] ht_pix_rdata;
  logic standby;
  logic bus_sel;
  logic accept;                           // edge at which waitrequest is low
  logic soft_rst;
  logic pix_en;
  logic line_end;

  // request bundle; only the low byte lane carries register data
  assign req = '{rd: avs_read_in, wr: avs_write_in & avs_byteenable_in[0],
                 idx: avs_address_in, wdata: avs_writedata_in[7:0]};
  assign accept = (state_q == htar_pkg::ST_ACK);
  assign standby = reg_q[htar_pkg::REG_MODE][htar_pkg::MODE_HOLD_BIT];
  assign bus_sel = reg_q[htar_pkg::REG_MODE][htar_pkg::MODE_BUS_SEL_BIT];
  // reset condition spans the whole pending write, not just its last edge
  assign soft_rst = req.wr && (req.idx == htar_pkg::REG_CTRL)
                    && req.wdata[htar_pkg::CTRL_RESET_BIT];

  // access sequencer: one wait cycle for registers, more for the external memory
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= htar_pkg::ST_IDLE;
      avs_waitrequest_out <= 1'b1;
      mem_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        htar_pkg::ST_IDLE: begin
          if ((req.rd || req.wr) && req.idx == htar_pkg::REG_SHADING && !bus_sel) begin
            state_q <= htar_pkg::ST_MEM;
            mem_cnt_q <= mem_cycles(reg_q[htar_pkg::REG_MEMCFG][htar_pkg::MEMCFG_CLK_LSB +: 2]);
          end else if (req.rd || avs_write_in) begin // a write with its lane off is still answered
            state_q <= htar_pkg::ST_ACK;
            avs_waitrequest_out <= 1'b0;
          end
        end
        htar_pkg::ST_MEM: begin
          // write strobe held for the programmed number of cycles; a read keeps its select and output enable through ST_SYNC as well
          if (mem_cnt_q == 3'h1) begin
            state_q <= req.rd ? htar_pkg::ST_SYNC : htar_pkg::ST_ACK;
            avs_waitrequest_out <= req.rd;
            mem_cnt_q <= 3'(htar_pkg::SYNC_STAGES);
          end else begin
            mem_cnt_q <= mem_cnt_q - 3'h1;
          end
        end
        htar_pkg::ST_SYNC: begin
          // let the memory data pass both synchroniser stages
          if (mem_cnt_q == 3'h1) begin
            state_q <= htar_pkg::ST_CAPT;
          end else begin
            mem_cnt_q <= mem_cnt_q - 3'h1;
          end
        end
        htar_pkg::ST_CAPT: begin
          state_q <= htar_pkg::ST_ACK;
          avs_waitrequest_out <= 1'b0;
        end
        htar_pkg::ST_ACK: begin
          state_q <= htar_pkg::ST_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
        default: begin
          state_q <= htar_pkg::ST_IDLE;
          avs_waitrequest_out <= 1'b1;
        end
      endcase
    end
  end

  // register writes take effect at the accepting edge; table ports store nothing here
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 16; i++) begin
        reg_q[i] <= htar_pkg::REG_RESET_VAL;
      end
    end else if (accept && req.wr && req.idx < htar_pkg::REG_HALFTONE) begin
      // reset bit is a command, never stored
      reg_q[req.idx] <= (req.idx == htar_pkg::REG_CTRL) ? {1'b0, req.wdata[6:0]} : req.wdata;
    end
  end

  // read data is loaded at the same edge at which waitrequest drops, and stands with it
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (state_q == htar_pkg::ST_IDLE && req.rd) begin
      case (req.idx)
        htar_pkg::REG_CTRL: avs_readdata_out <= {24'h0, standby, 1'b0, ht_addr_q};
        // table contents reach the bus only with bus_output_select cleared
        htar_pkg::REG_HALFTONE: avs_readdata_out <= bus_sel ? 32'h0 : {26'h0, ht_host_rdata};
        default: avs_readdata_out <= {24'h0, reg_q[req.idx]};
      endcase
    end else if (state_q == htar_pkg::ST_CAPT) begin
      avs_readdata_out <= {25'h0, dq_sync_q[htar_pkg::SHADING_W-1:0]};
    end
  end

  // halftone address counter; advances as the strobe completes
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ht_addr_q <= 6'h00;
    end else if (soft_rst || standby) begin
      ht_addr_q <= 6'h00;
    end else if (accept && (req.rd || req.wr) && req.idx == htar_pkg::REG_HALFTONE && !bus_sel) begin
      ht_addr_q <= ht_addr_q + 6'h01;
    end
  end

  // correction memory address counter, cleared by soft reset and by standby
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sh_addr_q <= 16'h0000;
    end else if (soft_rst || standby) begin
      sh_addr_q <= 16'h0000;
    end else if (accept && (req.rd || req.wr) && req.idx == htar_pkg::REG_SHADING && !bus_sel) begin
      sh_addr_q <= addr_wrap(sh_addr_q + 16'h0001, reg_q[htar_pkg::REG_MEMCFG][htar_pkg::MEMCFG_CFG_LSB +: 2]);
    end
  end

  // external memory pins; write strobe rises before the counter moves on
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sram_out <= '{addr: 16'h0000, dout: htar_pkg::SRAM_DATA_RESET, dq_oe: 1'b0,
                    ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1};
    end else if (state_q == htar_pkg::ST_IDLE && (req.rd || req.wr)
                 && req.idx == htar_pkg::REG_SHADING && !bus_sel) begin
      sram_out.addr <= sh_addr_q;
      sram_out.dout <= {1'b0, req.wdata[htar_pkg::SHADING_W-1:0]};
      sram_out.dq_oe <= req.wr;
      sram_out.ce_b <= 1'b0;
      sram_out.oe_b <= !req.rd;
      sram_out.we_b <= !req.wr;
    end else if (mem_cnt_q == 3'h1 && ((state_q == htar_pkg::ST_MEM && !req.rd)
                 || state_q == htar_pkg::ST_SYNC)) begin
      // reads keep the strobes until the data has crossed both synchroniser stages
      sram_out.dq_oe <= 1'b0;
      sram_out.ce_b <= 1'b1;
      sram_out.oe_b <= 1'b1;
      sram_out.we_b <= 1'b1;
    end
  end

  // memory data comes from outside the clock domain
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dq_meta_q <= 8'h00;
      dq_sync_q <= 8'h00;
    end else begin
      dq_meta_q <= sram_dq_in;
      dq_sync_q <= dq_meta_q;
    end
  end

  // clock generator: pixel enable every sixteen clocks, stopped in standby
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pix_div_q <= 4'h0;
      internal_clk_en_out <= 1'b0;
    end else if (standby) begin
      pix_div_q <= 4'h0;
      internal_clk_en_out <= 1'b0;
    end else begin
      pix_div_q <= pix_div_q + 4'h1;
      internal_clk_en_out <= (pix_div_q == 4'(htar_pkg::PIXEL_DIV - 1));
    end
  end
  assign pix_en = internal_clk_en_out;
  assign line_end = pix_en && (pix_cnt_q == PIX_W'(LINE_PIXELS - 1));

  // position in line; a soft reset abandons the line and starts the next one
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pix_cnt_q <= '0;
      line_abort_out <= 1'b0;
    end else begin
      line_abort_out <= soft_rst && accept;
      if (soft_rst) begin
        pix_cnt_q <= '0;
      end else if (line_end) begin
        pix_cnt_q <= '0;
      end else if (pix_en) begin
        pix_cnt_q <= pix_cnt_q + PIX_W'(1);
      end
    end
  end

  // line period counter survives standby and soft reset, only hard reset clears it
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      line_cnt_q <= 16'h0000;
    end else if (line_end || (soft_rst && accept)) begin
      line_cnt_q <= line_cnt_q + 16'h0001;
    end
  end

  // roller steps every line; with scale down only some lines carry data
  assign scale_sum = {1'b0, scale_acc_q} + {1'b0, htar_pkg::SCALE_NUM};
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      roller_step_timing_out <= 1'b0;
      line_kept_out <= 1'b1;
      scale_acc_q <= 4'h0;
    end else if (standby) begin
      roller_step_timing_out <= 1'b0;
      line_kept_out <= 1'b1;
      scale_acc_q <= 4'h0;
    end else begin
      roller_step_timing_out <= line_end;
      if (line_end && reg_q[htar_pkg::REG_SCALE][htar_pkg::SCALE_EN_BIT]) begin
        // keep numerator lines out of each denominator lines
        if (scale_sum >= {1'b0, htar_pkg::SCALE_DEN}) begin
          scale_acc_q <= 4'(scale_sum - {1'b0, htar_pkg::SCALE_DEN});
          line_kept_out <= 1'b1;
        end else begin
          scale_acc_q <= scale_sum[3:0];
          line_kept_out <= 1'b0;
        end
      end else if (line_end) begin
        line_kept_out <= 1'b1;
      end
    end
  end

  // matrix cell from line and pixel position
  assign ht_pix_addr = cell_index(line_cnt_q[2:0], pix_cnt_q[2:0],
                                  reg_q[htar_pkg::REG_MODE][htar_pkg::MODE_MATRIX8_BIT]);

  // bi-level and dither decisions; a larger coefficient blackens more pixels
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bilevel_black_out <= 1'b0;
      halftone_black_out <= 1'b0;
    end else if (standby) begin
      bilevel_black_out <= 1'b0;
      halftone_black_out <= 1'b0;
    end else if (pix_en) begin
      bilevel_black_out <= ({1'b0, pixel_in} < reg_q[htar_pkg::REG_COEF]);
      halftone_black_out <= (pixel_in[6:1] < ht_pix_rdata);
    end
  end

  // threshold table
  htar_halftone_mem #(
    .WORDS(htar_pkg::HALFTONE_WORDS),
    .WIDTH(htar_pkg::HALFTONE_W)
  ) u_halftone_mem (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .host_we_in(accept && req.wr && req.idx == htar_pkg::REG_HALFTONE && !bus_sel),
    .host_addr_in(ht_addr_q),
    .host_wdata_in(req.wdata[htar_pkg::HALFTONE_W-1:0]),
    .host_rdata_out(ht_host_rdata),
    .standby_in(standby),
    .pix_addr_in(ht_pix_addr),
    .pix_rdata_out(ht_pix_rdata)
  );

endmodule // htar_top
